/* src/rcr_regulator_control_registers.sv */
// Regulator control and status register bank
`timescale 1ns/10ps
// Overview of operation
// - Buck2/3 output code is the primary code while voltage select pin low.
// - Buck2/3 output code is the secondary code while voltage select pin high.
// - Control bit 7 written 1 turns regulator on, 0 turns it off.
// - Buck2 phase bit 1 shifts switching 180 degrees; 0 keeps in phase.
// - Mode bit 1 forces PWM at all loads; 0 permits light-load power saving.
// - Each buck control byte holds a 3-bit read/write turn-on delay code; the ldo1 control byte has none.
// - Buck fault mask bit 1 lets output faults raise interrupt; 0 suppresses them. Ldo1 bit 1 cannot be set, so ldo1 faults never do.
// - Power-good bit reads 1 while output above threshold, else 0.
// - Buck3 bit 6 at 0 enables buck3 whenever push-button input asserted.
// - Ldo1 has a single 6-bit voltage code, no alternate selection.
// - All bits return to defaults on power loss or undervoltage lockout.
module rcr_regulator_control_registers (
   input wire logic clk,
   input wire logic rst,
   input wire logic uvlo,
   input wire rcr_pkg::rcr_req_type req,
   output logic [7:0] rdata,
   input wire logic voltage_select_pin,
   input wire logic pushbutton_input_n,
   input wire logic [3:0] pgood_in,
   input wire logic [3:0] fault_in,
   output logic buck1_enable,
   output logic buck1_phase_shift,
   output logic buck1_forced_pwm,
   output logic [2:0] buck1_delay,
   output rcr_pkg::rcr_buck_type buck2_cfg,
   output rcr_pkg::rcr_buck_type buck3_cfg,
   output logic [5:0] ldo1_vout_code,
   output logic ldo1_enable,
   output logic fault_irq
);
   // ****************************************
   // Storage
   // ****************************************
   logic [7:0] b1_ctrl_r, b1_ctrl_nxt;
   logic [7:0] b2_pri_r, b2_pri_nxt;
   logic [7:0] b2_sec_r, b2_sec_nxt;
   logic [7:0] b2_ctrl_r, b2_ctrl_nxt;
   logic [7:0] b3_pri_r, b3_pri_nxt;
   logic [7:0] b3_sec_r, b3_sec_nxt;
   logic [7:0] b3_ctrl_r, b3_ctrl_nxt;
   logic [7:0] l1_volt_r, l1_volt_nxt;
   logic [7:0] l1_ctrl_r, l1_ctrl_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [3:0] pgood_r, pgood_nxt;
   logic [3:0] fault_irq_en;
   logic fault_irq_r, fault_irq_nxt;
   logic b2_use_sec_r, b2_use_sec_nxt;
   logic b3_pb_on_r, b3_pb_on_nxt;
   logic voltage_select_pin_level;
   logic pb_pressed;
   logic clear;

   // Pins cross from outside, so both pass the filtered synchroniser
   rcr_pin_sync u_voltage_select_pin_sync (
      .clk(clk),
      .rst(rst),
      .pin(voltage_select_pin),
      .level(voltage_select_pin_level)
   );

   // Pin is active low; inverted ahead of the synchroniser so that its
   // cleared state means released and no false press follows reset
   rcr_pin_sync u_pb_sync (
      .clk(clk),
      .rst(rst),
      .pin(!pushbutton_input_n),
      .level(pb_pressed)
   );

   // Write data with reserved positions forced to zero
   function automatic logic [7:0] rcr_store(
      input logic [7:0] old_val,
      input logic [7:0] wdata,
      input logic hit,
      input logic [7:0] mask
   );
      rcr_store = hit ? (wdata & mask) : old_val;
   endfunction : rcr_store

   function automatic logic rcr_hit(
      input rcr_pkg::rcr_req_type r,
      input logic [7:0] offset
   );
      rcr_hit = r.wr && (r.addr == offset);
   endfunction : rcr_hit

   // Control bytes read back with bit 0 replaced by live power-good status
   function automatic logic [7:0] rcr_ctrl_read(
      input logic [7:0] ctrl,
      input logic pg
   );
      rcr_ctrl_read = ctrl & rcr_pkg::RCR_CTRL_MASK;
      rcr_ctrl_read[rcr_pkg::RCR_PGOOD_BIT] = pg;
   endfunction : rcr_ctrl_read

   // Active code of a converter: the select pin picks secondary over primary
   function automatic logic [rcr_pkg::RCR_CODE_W-1:0] rcr_pick_code(
      input logic use_sec,
      input logic [7:0] pri,
      input logic [7:0] sec
   );
      rcr_pick_code = use_sec ? sec[rcr_pkg::RCR_CODE_W-1:0]
                              : pri[rcr_pkg::RCR_CODE_W-1:0];
   endfunction : rcr_pick_code

   // ****************************************
   // Next values
   // ****************************************
   always_comb begin
      clear = rst || uvlo;
      b1_ctrl_nxt = rcr_store(b1_ctrl_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK1_CONTROL), rcr_pkg::RCR_CTRL_MASK);
      b2_pri_nxt = rcr_store(b2_pri_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK2_PRIMARY), rcr_pkg::RCR_CODE_MASK);
      b2_sec_nxt = rcr_store(b2_sec_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK2_SECONDARY), rcr_pkg::RCR_CODE_MASK);
      b2_ctrl_nxt = rcr_store(b2_ctrl_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK2_CONTROL), rcr_pkg::RCR_CTRL_MASK);
      b3_pri_nxt = rcr_store(b3_pri_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK3_PRIMARY), rcr_pkg::RCR_CODE_MASK);
      b3_sec_nxt = rcr_store(b3_sec_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK3_SECONDARY), rcr_pkg::RCR_CODE_MASK);
      b3_ctrl_nxt = rcr_store(b3_ctrl_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_BUCK3_CONTROL), rcr_pkg::RCR_CTRL_MASK);
      l1_volt_nxt = rcr_store(l1_volt_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_LDO1_VOLTAGE), rcr_pkg::RCR_CODE_MASK);
      // Other ldo1 control fields lie outside this bank and read as zero
      l1_ctrl_nxt = rcr_store(l1_ctrl_r, req.wdata,
         rcr_hit(req, rcr_pkg::RCR_LDO1_CONTROL),
         rcr_pkg::RCR_LDO_CTRL_MASK);
      pgood_nxt = pgood_in;
      b2_use_sec_nxt = voltage_select_pin_level;
      b3_pb_on_nxt = !b3_ctrl_r[rcr_pkg::RCR_PHASE_BIT] && pb_pressed;
      fault_irq_en = {l1_ctrl_r[rcr_pkg::RCR_FLT_BIT],
                      b3_ctrl_r[rcr_pkg::RCR_FLT_BIT],
                      b2_ctrl_r[rcr_pkg::RCR_FLT_BIT],
                      b1_ctrl_r[rcr_pkg::RCR_FLT_BIT]};
      fault_irq_nxt = |(fault_in & fault_irq_en);
      rdata_nxt = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            rcr_pkg::RCR_BUCK1_CONTROL:
               rdata_nxt = rcr_ctrl_read(b1_ctrl_r, pgood_r[0]);
            rcr_pkg::RCR_BUCK2_PRIMARY: rdata_nxt = b2_pri_r;
            rcr_pkg::RCR_BUCK2_SECONDARY: rdata_nxt = b2_sec_r;
            rcr_pkg::RCR_BUCK2_CONTROL:
               rdata_nxt = rcr_ctrl_read(b2_ctrl_r, pgood_r[1]);
            rcr_pkg::RCR_BUCK3_PRIMARY: rdata_nxt = b3_pri_r;
            rcr_pkg::RCR_BUCK3_SECONDARY: rdata_nxt = b3_sec_r;
            rcr_pkg::RCR_BUCK3_CONTROL:
               rdata_nxt = rcr_ctrl_read(b3_ctrl_r, pgood_r[2]);
            rcr_pkg::RCR_LDO1_VOLTAGE: rdata_nxt = l1_volt_r;
            rcr_pkg::RCR_LDO1_CONTROL:
               rdata_nxt = rcr_ctrl_read(l1_ctrl_r, pgood_r[3]);
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (clear) begin
         b1_ctrl_r <= rcr_pkg::RCR_CTRL_RESET;
         b2_pri_r <= rcr_pkg::RCR_CODE_RESET;
         b2_sec_r <= rcr_pkg::RCR_CODE_RESET;
         b2_ctrl_r <= rcr_pkg::RCR_CTRL_RESET;
         b3_pri_r <= rcr_pkg::RCR_CODE_RESET;
         b3_sec_r <= rcr_pkg::RCR_CODE_RESET;
         b3_ctrl_r <= rcr_pkg::RCR_CTRL_RESET;
         l1_volt_r <= rcr_pkg::RCR_CODE_RESET;
         l1_ctrl_r <= rcr_pkg::RCR_CTRL_RESET;
         rdata_r <= 8'h00;
         pgood_r <= 4'h0;
         fault_irq_r <= 1'b0;
         b2_use_sec_r <= 1'b0;
         b3_pb_on_r <= 1'b0;
      end else begin
         b1_ctrl_r <= b1_ctrl_nxt;
         b2_pri_r <= b2_pri_nxt;
         b2_sec_r <= b2_sec_nxt;
         b2_ctrl_r <= b2_ctrl_nxt;
         b3_pri_r <= b3_pri_nxt;
         b3_sec_r <= b3_sec_nxt;
         b3_ctrl_r <= b3_ctrl_nxt;
         l1_volt_r <= l1_volt_nxt;
         l1_ctrl_r <= l1_ctrl_nxt;
         rdata_r <= rdata_nxt;
         pgood_r <= pgood_nxt;
         fault_irq_r <= fault_irq_nxt;
         b2_use_sec_r <= b2_use_sec_nxt;
         b3_pb_on_r <= b3_pb_on_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata = rdata_r;
   assign fault_irq = fault_irq_r;
   assign buck1_enable = b1_ctrl_r[rcr_pkg::RCR_ON_BIT];
   assign buck1_phase_shift = b1_ctrl_r[rcr_pkg::RCR_PHASE_BIT];
   assign buck1_forced_pwm = b1_ctrl_r[rcr_pkg::RCR_MODE_BIT];
   assign buck1_delay = b1_ctrl_r[rcr_pkg::RCR_DELAY_LSB +: rcr_pkg::RCR_DELAY_W];

   assign buck2_cfg.enable = b2_ctrl_r[rcr_pkg::RCR_ON_BIT];
   assign buck2_cfg.phase_shift = b2_ctrl_r[rcr_pkg::RCR_PHASE_BIT];
   assign buck2_cfg.forced_pwm = b2_ctrl_r[rcr_pkg::RCR_MODE_BIT];
   assign buck2_cfg.delay =
      b2_ctrl_r[rcr_pkg::RCR_DELAY_LSB +: rcr_pkg::RCR_DELAY_W];
   assign buck2_cfg.fault_irq_en = b2_ctrl_r[rcr_pkg::RCR_FLT_BIT];
   assign buck2_cfg.vout_code = rcr_pick_code(b2_use_sec_r, b2_pri_r,
                                              b2_sec_r);

   // Bit 6 here is push-button response, so no phase shift for buck3
   assign buck3_cfg.enable = b3_ctrl_r[rcr_pkg::RCR_ON_BIT]
                             || b3_pb_on_r;
   assign buck3_cfg.phase_shift = 1'b0;
   assign buck3_cfg.forced_pwm = b3_ctrl_r[rcr_pkg::RCR_MODE_BIT];
   assign buck3_cfg.delay =
      b3_ctrl_r[rcr_pkg::RCR_DELAY_LSB +: rcr_pkg::RCR_DELAY_W];
   assign buck3_cfg.fault_irq_en = b3_ctrl_r[rcr_pkg::RCR_FLT_BIT];
   assign buck3_cfg.vout_code = rcr_pick_code(b2_use_sec_r, b3_pri_r,
                                              b3_sec_r);

   assign ldo1_vout_code = l1_volt_r[rcr_pkg::RCR_CODE_W-1:0];
   assign ldo1_enable = l1_ctrl_r[rcr_pkg::RCR_ON_BIT];
endmodule : rcr_regulator_control_registers

/* src/rcr_pkg.sv */
// Package: register map, field layout and carrier types for the regulator bank
package rcr_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] RCR_BUCK1_CONTROL = 8'h22;
   localparam logic [7:0] RCR_BUCK2_PRIMARY = 8'h30;
   localparam logic [7:0] RCR_BUCK2_SECONDARY = 8'h31;
   localparam logic [7:0] RCR_BUCK2_CONTROL = 8'h32;
   localparam logic [7:0] RCR_BUCK3_PRIMARY = 8'h40;
   localparam logic [7:0] RCR_BUCK3_SECONDARY = 8'h41;
   localparam logic [7:0] RCR_BUCK3_CONTROL = 8'h42;
   localparam logic [7:0] RCR_LDO1_VOLTAGE = 8'h50;
   localparam logic [7:0] RCR_LDO1_CONTROL = 8'h51;

   // ****************************************
   // Field positions and masks
   // ****************************************
   localparam int RCR_ON_BIT = 7;
   localparam int RCR_PHASE_BIT = 6;
   localparam int RCR_MODE_BIT = 5;
   localparam int RCR_DELAY_LSB = 2;
   localparam int RCR_FLT_BIT = 1;
   localparam int RCR_PGOOD_BIT = 0;
   localparam int RCR_CODE_W = 6;
   localparam int RCR_DELAY_W = 3;
   localparam logic [7:0] RCR_CODE_MASK = 8'h3F;
   localparam logic [7:0] RCR_CTRL_MASK = 8'hFE;
   localparam logic [7:0] RCR_LDO_CTRL_MASK = 8'h80;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] RCR_CODE_RESET = 8'h00;
   localparam logic [7:0] RCR_CTRL_RESET = 8'h00;

   localparam int RCR_SYNC_STAGES = 3;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcr_req_type;

   typedef struct packed {
      logic enable;
      logic phase_shift;
      logic forced_pwm;
      logic [RCR_DELAY_W-1:0] delay;
      logic fault_irq_en;
      logic [RCR_CODE_W-1:0] vout_code;
   } rcr_buck_type;
endpackage : rcr_pkg

/* src/rcr_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module rcr_pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   output logic level
);
   logic [rcr_pkg::RCR_SYNC_STAGES-1:0] sync_r;
   logic [rcr_pkg::RCR_SYNC_STAGES-1:0] sync_nxt;
   logic level_r;
   logic level_nxt;

   // ****************************************
   // Next state
   // ****************************************
   // Stage 0 only feeds stage 1; level moves when stages 1 and 2 agree
   always_comb begin
      sync_nxt = {sync_r[1:0], pin};
      level_nxt = level_r;
      if (sync_r[1] == sync_r[2]) begin
         level_nxt = sync_r[2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_r <= '0;
         level_r <= 1'b0;
      end else begin
         sync_r <= sync_nxt;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule : rcr_pin_sync

/* testbench/rcr_checker.sv */
// Checker: port-level assertions for the regulator register bank
`timescale 1ns/10ps
module rcr_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic uvlo,
   input wire rcr_pkg::rcr_req_type req,
   input wire logic [7:0] rdata,
   input wire logic [3:0] fault_in,
   input wire logic buck1_enable,
   input wire logic buck1_phase_shift,
   input wire logic buck1_forced_pwm,
   input wire logic [2:0] buck1_delay,
   input wire rcr_pkg::rcr_buck_type buck2_cfg,
   input wire rcr_pkg::rcr_buck_type buck3_cfg,
   input wire logic [5:0] ldo1_vout_code,
   input wire logic ldo1_enable,
   input wire logic fault_irq
);
   // ********
   // Assertions
   // ********
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic wr_ok;
   logic [7:0] wd;
   assign wr_ok = req.wr && !uvlo;
   assign wd = req.wdata;
   property p_b1;
      wr_ok && req.addr == 8'h22 |=> {buck1_enable, buck1_phase_shift,
         buck1_forced_pwm, buck1_delay} == $past(wd[7:2]);
   endproperty
   a_b1: assert property (p_b1) else $error("buck1 control");
   property p_b2;
      wr_ok && req.addr == 8'h32 |=> buck2_cfg[12:6] == $past(wd[7:1]);
   endproperty
   a_b2: assert property (p_b2) else $error("buck2 control");
   // Bit 6 of this byte is the push-button select, so phase stays 0
   property p_b3;
      wr_ok && req.addr == 8'h42 |=> buck3_cfg[11:6] == {1'b0, $past(wd[5:1])};
   endproperty
   a_b3: assert property (p_b3) else $error("buck3 control");
   property p_len;
      wr_ok && req.addr == 8'h51 |=> ldo1_enable == $past(wd[7]);
   endproperty
   a_len: assert property (p_len) else $error("ldo1 enable");
   property p_lv;
      wr_ok && req.addr == 8'h50 |=> ldo1_vout_code == $past(wd[5:0]);
   endproperty
   a_lv: assert property (p_lv) else $error("ldo1 code");
   property p_rsv;
      req.rd && req.addr[7:1] == 7'h18 |=> rdata[7:6] == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_f0;
      fault_in == 4'h0 |=> !fault_irq;
   endproperty
   a_f0: assert property (p_f0) else $error("irq no fault");
   property p_f1;
      fault_in[1] && buck2_cfg.fault_irq_en && !uvlo |=> fault_irq;
   endproperty
   a_f1: assert property (p_f1) else $error("irq missing");
   property p_uv;
      uvlo |=> buck2_cfg == '0 && !ldo1_enable;
   endproperty
   a_uv: assert property (p_uv) else $error("uvlo clear");
endmodule : rcr_checker

bind rcr_regulator_control_registers rcr_checker u_rcr_checker (
   .clk, .rst, .uvlo, .req, .rdata, .fault_in, .buck1_enable,
   .buck1_phase_shift, .buck1_forced_pwm, .buck1_delay, .buck2_cfg, .buck3_cfg,
   .ldo1_vout_code, .ldo1_enable, .fault_irq);

/* testbench/rcr_host_model.sv */
// Host model: register requests as one-cycle strobes
`timescale 1ns/10ps
module rcr_host_model (
   input wire logic clk,
   output rcr_pkg::rcr_req_type req
);
   logic [7:0] exp_q [$];
   initial req = '0;
   // Strobe drops at the edge that takes it, so calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= {2'h2, a, d};
      @(posedge clk);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      req <= {2'h1, a, 8'h00};
      @(posedge clk);
      req <= '0;
   endtask : rd
endmodule : rcr_host_model

/* testbench/tb_rcr_regulator_control_registers.sv */
// Testbench: regulator register bank
`timescale 1ns/10ps
module tb_rcr_regulator_control_registers;
   logic clk = 0, rst = 1, uvlo = 0, sel = 0, pb_n = 1, fault_irq, rd_d = 0;
   logic [3:0] pgood = 4'h7, fault = 4'h0;
   logic [7:0] rdata, ev, lf = 8'h5F;
   logic [5:0] lv;
   logic [7:0] wv [9];
   logic [7:0] adr [9] = '{8'h22, 8'h30, 8'h31, 8'h32, 8'h40, 8'h41, 8'h42,
      8'h50, 8'h51};
   logic [7:0] msk [9] = '{8'hFE, 8'h3F, 8'h3F, 8'hFE, 8'h3F, 8'h3F, 8'hFE,
      8'h3F, 8'h80};
   rcr_pkg::rcr_req_type req;
   rcr_pkg::rcr_buck_type b2, b3;
   int errors = 0, cmp_count = 0;
   rcr_host_model u_rcr_host_model (.clk, .req);
   rcr_regulator_control_registers u_rcr_regulator_control_registers (
      .clk, .rst, .uvlo, .req, .rdata, .voltage_select_pin(sel),
      .pushbutton_input_n(pb_n), .pgood_in(pgood), .fault_in(fault),
      .buck1_enable(), .buck1_phase_shift(), .buck1_forced_pwm(),
      .buck1_delay(), .buck2_cfg(b2), .buck3_cfg(b3), .ldo1_vout_code(lv),
      .ldo1_enable(), .fault_irq);
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nxt
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // ********
   // Read monitor: rdata stands one cycle after the request is taken
   // ********
   always @(posedge clk) rd_d <= req.rd;
   always @(negedge clk) begin
      if (rd_d) check(rdata, u_rcr_host_model.exp_q.pop_front());
   end
   initial begin
      #200000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         u_rcr_host_model.rd(adr[i], {7'h0, msk[i] == 8'hFE});
      end
      $display("test done: reset values");
      for (int i = 0; i < 9; i++) begin
         lf = nxt(lf);
         wv[i] = lf;
         ev = (lf & msk[i]) | {7'h0, msk[i] == 8'hFE};
         u_rcr_host_model.wr(adr[i], lf);
         u_rcr_host_model.rd(adr[i], ev);
      end
      u_rcr_host_model.wr(8'h33, 8'hFF);
      u_rcr_host_model.rd(8'h33, 8'h00);
      $display("test done: write and read back");
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         sel <= s[0];
         repeat (8) @(posedge clk);
         #1;
         check({2'h0, b2.vout_code}, wv[1 + s] & 8'h3F);
         check({2'h0, b3.vout_code}, wv[4 + s] & 8'h3F);
         check({2'h0, lv}, wv[7] & 8'h3F);
      end
      $display("test done: voltage select");
      u_rcr_host_model.wr(8'h42, 8'h00);
      pb_n <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check({7'h0, b3.enable}, 8'h01);
      u_rcr_host_model.wr(8'h42, 8'h40);
      repeat (2) @(posedge clk);
      #1;
      check({7'h0, b3.enable}, 8'h00);
      @(posedge clk);
      pb_n <= 1'b1;
      fault <= 4'h2;
      $display("test done: push-button");
      for (int m = 1; m >= 0; m--) begin
         u_rcr_host_model.wr(8'h32, {6'h0, m[0], 1'b0});
         repeat (3) @(posedge clk);
         #1;
         check({7'h0, fault_irq}, {7'h0, m[0]});
      end
      $display("test done: fault mask");
      @(posedge clk);
      lf = nxt(lf);
      pgood <= lf[3:0];
      uvlo <= 1'b1;
      @(posedge clk);
      uvlo <= 1'b0;
      u_rcr_host_model.rd(8'h31, 8'h00);
      u_rcr_host_model.rd(8'h42, {7'h0, lf[2]});
      u_rcr_host_model.rd(8'h51, {7'h0, lf[3]});
      repeat (3) @(posedge clk);
      $display("test done: undervoltage clear");
      report_and_stop();
   end
endmodule : tb_rcr_regulator_control_registers
